// ===== rtl/bas_defs.vh
// Functional notes
// - Single, undefined INCR, fixed 4/8/16 bursts
// - Incrementing beats add size in bytes
// - Wrap boundary is beats times size
// - Three-bit burst type encoding as listed
// - Never start incrementing burst across 1KB
// - Single may be SINGLE or one-beat INCR
// - Length counts beats, not bytes
// - Every beat address aligned to its size
// - IDLE transfers also carry aligned address
// - Insert BUSY between beats when data late
// - Undefined INCR may end after BUSY
// - Fixed bursts end on SEQ, never BUSY
// - No BUSY directly after a SINGLE
// - After ERROR, abandon or continue burst
// - Abandoned beats need not be reissued
// - Transfer type: IDLE/BUSY/NONSEQ/SEQ encoding
// - Size field 8<<n bits, within bus width
// - Size held constant across a burst
`ifndef BAS_DEFS_VH
`define BAS_DEFS_VH

`define BAS_TRANS_IDLE   2'h0
`define BAS_TRANS_BUSY   2'h1
`define BAS_TRANS_NONSEQ 2'h2
`define BAS_TRANS_SEQ    2'h3

`define BAS_BURST_SINGLE 3'h0
`define BAS_BURST_INCR   3'h1
`define BAS_BURST_WRAP4  3'h2
`define BAS_BURST_INCR4  3'h3
`define BAS_BURST_WRAP8  3'h4
`define BAS_BURST_INCR8  3'h5
`define BAS_BURST_WRAP16 3'h6
`define BAS_BURST_INCR16 3'h7

`define BAS_SIZE_BYTE    3'h0
`define BAS_SIZE_WORD    3'h2
`define BAS_KB_BITS      10

`define BAS_ADDR_RESET   32'h00000000
`define BAS_DATA_RESET   32'h00000000
`define BAS_FIFO_WIDTH   32
`define BAS_FIFO_DEPTH   4
`define BAS_FIFO_AW      2

`endif

// ===== rtl/bas_fifo.v
`timescale 1ns/1ps
module bas_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clock_in,
  input  wire             reset_n_in,
  input  wire             flush_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_reg != DEPTH[AW:0]);
  assign out_valid_out = (count_reg != {(AW+1){1'b0}});
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out & ~flush_in;
  assign pop           = out_valid_out & out_ready_in & ~flush_in;

  always @(posedge clock_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ===== rtl/bas_sequencer.v
`timescale 1ns/1ps
`include "bas_defs.vh"
module bas_sequencer (
  input  wire        clock_in,
  input  wire        reset_n_in,
  input  wire        cmd_valid_in,
  output wire        cmd_ready_out,
  input  wire [31:0] cmd_addr_in,
  input  wire [2:0]  cmd_burst_in,
  input  wire [2:0]  cmd_size_in,
  input  wire        cmd_write_in,
  input  wire [7:0]  cmd_len_in,
  input  wire        wdata_valid_in,
  output wire        wdata_ready_out,
  input  wire [31:0] wdata_in,
  output wire [31:0] rdata_out,
  output wire        rdata_valid_out,
  output wire        error_out,
  output wire        busy_out,
  output wire [31:0] haddr_out,
  output wire [1:0]  htrans_out,
  output wire [2:0]  hburst_out,
  output wire [2:0]  hsize_out,
  output wire        hwrite_out,
  output wire [31:0] hwdata_out,
  input  wire        hready_in,
  input  wire        hresp_in,
  input  wire [31:0] hrdata_in
);
  reg  [31:0] addr_reg,   addr_next;
  reg  [1:0]  trans_reg,  trans_next;
  reg  [2:0]  burst_reg,  burst_next;
  reg  [2:0]  size_reg,   size_next;
  reg         write_reg,  write_next;
  reg  [7:0]  beats_reg,  beats_next;
  reg         active_reg, active_next;
  reg         first_reg,  first_next;
  reg  [31:0] stage_reg,  stage_next;
  reg  [31:0] hwdata_reg, hwdata_next;
  reg         dvalid_reg, dvalid_next;
  reg         dwrite_reg, dwrite_next;
  reg  [31:0] rdata_reg,  rdata_next;
  reg         rvalid_reg, rvalid_next;
  reg         err_reg,    err_next;
  reg         fifo_pop;
  reg         fifo_flush;
  reg         take;
  reg  [7:0]  left;
  reg  [31:0] adv;
  reg  [2:0]  ld_size;
  reg  [7:0]  ld_beats;
  reg  [31:0] ld_addr;
  reg  [31:0] ld_end;
  wire        fifo_valid;
  wire [31:0] fifo_data;

  // Beats of a burst type; undefined INCR takes the requested length, zero meaning one
  function [7:0] f_beats;
    input [2:0] burst;
    input [7:0] len;
    begin
      case (burst)
        `BAS_BURST_SINGLE: f_beats = 8'h01;
        `BAS_BURST_INCR:   f_beats = (len == 8'h00) ? 8'h01 : len;
        `BAS_BURST_WRAP4,
        `BAS_BURST_INCR4:  f_beats = 8'h04;
        `BAS_BURST_WRAP8,
        `BAS_BURST_INCR8:  f_beats = 8'h08;
        default:           f_beats = 8'h10;
      endcase
    end
  endfunction

  function [31:0] f_size_mask;
    input [2:0] size;
    begin
      f_size_mask = (32'h00000001 << size) - 32'h00000001;
    end
  endfunction

  // Address of the following beat
  function [31:0] f_next;
    input [31:0] addr;
    input [2:0]  size;
    input [2:0]  burst;
    reg   [31:0] incr;
    reg   [31:0] mask;
    begin
      incr = addr + (32'h00000001 << size);
      mask = ({24'h000000, f_beats(burst, 8'h01)} << size) - 32'h00000001;
      if (burst[0] == 1'b0 && burst != `BAS_BURST_SINGLE) begin
        f_next = (addr & ~mask) | (incr & mask);
      end else begin
        f_next = incr;
      end
    end
  endfunction

  bas_fifo #(
    .WIDTH (`BAS_FIFO_WIDTH),
    .DEPTH (`BAS_FIFO_DEPTH),
    .AW    (`BAS_FIFO_AW)
  ) u_fifo (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .flush_in      (fifo_flush),
    .in_valid_in   (wdata_valid_in),
    .in_ready_out  (wdata_ready_out),
    .in_data_in    (wdata_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  assign cmd_ready_out   = ~active_reg & hready_in;
  assign busy_out        = active_reg;
  assign haddr_out       = addr_reg;
  assign htrans_out      = trans_reg;
  assign hburst_out      = burst_reg;
  assign hsize_out       = size_reg;
  assign hwrite_out      = write_reg;
  assign hwdata_out      = hwdata_reg;
  assign rdata_out       = rdata_reg;
  assign rdata_valid_out = rvalid_reg;
  assign error_out       = err_reg;

  always @* begin
    addr_next   = addr_reg;
    trans_next  = trans_reg;
    burst_next  = burst_reg;
    size_next   = size_reg;
    write_next  = write_reg;
    beats_next  = beats_reg;
    active_next = active_reg;
    first_next  = first_reg;
    stage_next  = stage_reg;
    hwdata_next = hwdata_reg;
    dvalid_next = dvalid_reg;
    dwrite_next = dwrite_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    err_next    = 1'b0;
    fifo_pop    = 1'b0;
    fifo_flush  = 1'b0;
    take        = hready_in & trans_reg[1];
    left        = beats_reg - {7'h00, take};
    adv         = take ? f_next(addr_reg, size_reg, burst_reg) : addr_reg;
    ld_size     = (cmd_size_in > `BAS_SIZE_WORD) ? `BAS_SIZE_WORD : cmd_size_in;
    ld_beats    = f_beats(cmd_burst_in, cmd_len_in);
    ld_addr     = cmd_addr_in & ~f_size_mask(ld_size);
    ld_end      = ld_addr + ({24'h000000, ld_beats} << ld_size) - 32'h00000001;
    if (dvalid_reg & hresp_in & ~hready_in) begin
      // First error cycle: drop the rest of the burst, queued write data too
      trans_next  = `BAS_TRANS_IDLE;
      active_next = 1'b0;
      beats_next  = 8'h00;
      fifo_flush  = 1'b1;
      err_next    = 1'b1;
    end else if (hready_in) begin
      beats_next  = left;
      addr_next   = adv;
      dvalid_next = take;
      dwrite_next = write_reg;
      first_next  = first_reg & ~take;
      if (take & write_reg) begin
        hwdata_next = stage_reg;
      end
      if (dvalid_reg & ~dwrite_reg & ~hresp_in) begin
        rdata_next  = hrdata_in;
        rvalid_next = 1'b1;
      end
      if (active_reg && left != 8'h00) begin
        if (~write_reg | fifo_valid) begin
          fifo_pop   = write_reg;
          stage_next = fifo_data;
          if (first_next) begin
            trans_next = `BAS_TRANS_NONSEQ;
          end else if (burst_reg[0] && adv[`BAS_KB_BITS-1:0] == 10'h000) begin
            // Reaching a 1KB line restarts as an undefined burst
            trans_next = `BAS_TRANS_NONSEQ;
            burst_next = `BAS_BURST_INCR;
          end else begin
            trans_next = `BAS_TRANS_SEQ;
          end
        end else begin
          // Before the first beat there is no burst yet, so BUSY is not allowed
          trans_next = first_next ? `BAS_TRANS_IDLE : `BAS_TRANS_BUSY;
        end
      end else if (active_reg) begin
        // Counted burst is over: the last beat was SEQ or NONSEQ
        trans_next  = `BAS_TRANS_IDLE;
        active_next = 1'b0;
        addr_next   = addr_reg & ~f_size_mask(size_reg);
      end else if (cmd_valid_in) begin
        addr_next   = ld_addr;
        trans_next  = `BAS_TRANS_IDLE;
        size_next   = ld_size;
        write_next  = cmd_write_in;
        beats_next  = ld_beats;
        active_next = 1'b1;
        first_next  = 1'b1;
        burst_next  = cmd_burst_in;
        if (cmd_burst_in[0] && ld_addr[31:`BAS_KB_BITS] != ld_end[31:`BAS_KB_BITS]) begin
          burst_next = `BAS_BURST_INCR;
        end
      end
    end
  end

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_reg   <= `BAS_ADDR_RESET;
      trans_reg  <= `BAS_TRANS_IDLE;
      burst_reg  <= `BAS_BURST_SINGLE;
      size_reg   <= `BAS_SIZE_WORD;
      write_reg  <= 1'b0;
      beats_reg  <= 8'h00;
      active_reg <= 1'b0;
      first_reg  <= 1'b0;
      stage_reg  <= `BAS_DATA_RESET;
      hwdata_reg <= `BAS_DATA_RESET;
      dvalid_reg <= 1'b0;
      dwrite_reg <= 1'b0;
      rdata_reg  <= `BAS_DATA_RESET;
      rvalid_reg <= 1'b0;
      err_reg    <= 1'b0;
    end else begin
      addr_reg   <= addr_next;
      trans_reg  <= trans_next;
      burst_reg  <= burst_next;
      size_reg   <= size_next;
      write_reg  <= write_next;
      beats_reg  <= beats_next;
      active_reg <= active_next;
      first_reg  <= first_next;
      stage_reg  <= stage_next;
      hwdata_reg <= hwdata_next;
      dvalid_reg <= dvalid_next;
      dwrite_reg <= dwrite_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      err_reg    <= err_next;
    end
  end
endmodule

// ===== verif/bas_sequencer_asserts.sv
`timescale 1ns/1ps
`include "bas_defs.vh"
module bas_chk (
  input wire        clock_in,
  input wire        reset_n_in,
  input wire        hready_in,
  input wire        hresp_in,
  input wire [1:0]  htrans_out,
  input wire [31:0] haddr_out,
  input wire [2:0]  hburst_out,
  input wire [2:0]  hsize_out,
  input wire        error_out,
  input wire        busy_out
);
  reg         dph_reg;
  reg  [4:0]  cnt_reg;
  wire        take = hready_in && htrans_out[1];
  wire [31:0] sz   = 32'h1 << hsize_out;
  wire [31:0] nb   = 32'h2 << hburst_out[2:1];
  wire [31:0] wm   = nb * sz - 32'h1;
  // Beat count restarts on every first beat, so a cut burst leaves nothing behind
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dph_reg <= 1'h0;
      cnt_reg <= 5'h0;
    end else if (hready_in) begin
      dph_reg <= htrans_out[1];
      if (htrans_out[1])
        cnt_reg <= (htrans_out == `BAS_TRANS_NONSEQ) ? 5'h1 : cnt_reg + 5'h1;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_step;
    htrans_out == `BAS_TRANS_SEQ && $past(take);
  endsequence
  sequence s_busy_fixed;
    htrans_out == `BAS_TRANS_BUSY && hburst_out > `BAS_BURST_INCR;
  endsequence
  property p_align;
    (hsize_out != 3'h2 || haddr_out[1:0] == 2'h0) && (hsize_out != 3'h1 || !haddr_out[0]);
  endproperty
  a_align: assert property (p_align) else $error("unaligned address");
  property p_incr;
    s_step ##0 hburst_out[0] |-> haddr_out == $past(haddr_out) + sz;
  endproperty
  a_incr: assert property (p_incr) else $error("bad increment");
  property p_wrap;
    s_step ##0 (hburst_out[2:1] != 2'h0 && !hburst_out[0])
      |-> haddr_out == (($past(haddr_out) & ~wm) | (($past(haddr_out) + sz) & wm));
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad wrap");
  property p_ctrl;
    htrans_out[0] |-> $stable(hburst_out) && $stable(hsize_out);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control changed in burst");
  property p_kb;
    htrans_out == `BAS_TRANS_SEQ && hburst_out[0] |-> haddr_out[9:0] != 10'h0;
  endproperty
  a_kb: assert property (p_kb) else $error("1KB crossed");
  property p_single;
    take && hburst_out == `BAS_BURST_SINGLE |=> htrans_out != `BAS_TRANS_BUSY;
  endproperty
  a_single: assert property (p_single) else $error("busy after single");
  // A fixed burst may only leave BUSY for SEQ, unless an error cut it
  property p_fixed_end;
    s_busy_fixed |=> htrans_out[0] || error_out;
  endproperty
  a_fixed_end: assert property (p_fixed_end) else $error("fixed burst ends busy");
  property p_err;
    dph_reg && hresp_in && !hready_in |=> !htrans_out[1] && error_out && !busy_out;
  endproperty
  a_err: assert property (p_err) else $error("error not handled");
  property p_count;
    take && htrans_out == `BAS_TRANS_SEQ && hburst_out > `BAS_BURST_INCR
      |-> {27'h0, cnt_reg} < nb;
  endproperty
  a_count: assert property (p_count) else $error("too many beats");
endmodule
bind bas_sequencer bas_chk u_chk (.clock_in(clock_in), .reset_n_in(reset_n_in),
  .hready_in(hready_in), .hresp_in(hresp_in), .htrans_out(htrans_out),
  .haddr_out(haddr_out), .hburst_out(hburst_out), .hsize_out(hsize_out),
  .error_out(error_out), .busy_out(busy_out));

// ===== verif/bas_slave.sv
`timescale 1ns/1ps
module bas_slave (
  input  wire        clock_in,
  input  wire        reset_n_in,
  input  wire [1:0]  htrans_in,
  input  wire [31:0] haddr_in,
  input  wire        slow_in,
  input  wire        err_en_in,
  input  wire [31:0] err_addr_in,
  output reg         hready_out,
  output reg         hresp_out,
  output reg  [31:0] hrdata_out
);
  reg        err2_reg;
  reg [31:0] addr_reg;
  wire       hit = err_en_in && haddr_in == err_addr_in;
  // No burst state kept: a burst cut short leaves nothing stale
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hready_out <= 1'h1;
      hresp_out  <= 1'h0;
      hrdata_out <= 32'h0;
      err2_reg   <= 1'h0;
      addr_reg   <= 32'h0;
    end else if (err2_reg) begin
      hready_out <= 1'h1;
      err2_reg   <= 1'h0;
      hrdata_out <= ~hrdata_out;
    end else if (!hready_out) begin
      hready_out <= 1'h1;
      hrdata_out <= addr_reg ^ 32'h5A5A0000;
    end else if (htrans_in[1]) begin
      addr_reg   <= haddr_in;
      hresp_out  <= hit;
      err2_reg   <= hit;
      hready_out <= !(hit || slow_in);
      hrdata_out <= (hit || slow_in) ? ~hrdata_out : haddr_in ^ 32'h5A5A0000;
    end else begin
      hresp_out  <= 1'h0;
      hrdata_out <= ~hrdata_out;
    end
  end
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  reg         clock_in = 1'h0, reset_n_in = 1'h0, cmd_valid_in = 1'h0, cmd_write_in = 1'h0;
  reg         wdata_valid_in = 1'h0, slow = 1'h0, err_en = 1'h0, wph = 1'h0;
  reg  [31:0] cmd_addr_in = 32'h0, wdata_in = 32'h0, err_addr = 32'h0;
  reg  [2:0]  cmd_burst_in = 3'h0, cmd_size_in = 3'h0, fb, fz;
  reg  [7:0]  cmd_len_in = 8'h0;
  wire        cmd_ready_out, wdata_ready_out, rdata_valid_out, error_out, busy_out;
  wire        hwrite_out, hready_in, hresp_in;
  wire [31:0] rdata_out, haddr_out, hwdata_out, hrdata_in;
  wire [1:0]  htrans_out;
  wire [2:0]  hburst_out, hsize_out;
  reg  [31:0] ta[0:63], rd[0:63], wd[0:63];
  int         n_errors = 0, num_checks = 0, nt, nr, nw, ne;
  bas_sequencer DUT (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_addr_in(cmd_addr_in),
    .cmd_burst_in(cmd_burst_in), .cmd_size_in(cmd_size_in), .cmd_write_in(cmd_write_in),
    .cmd_len_in(cmd_len_in), .wdata_valid_in(wdata_valid_in),
    .wdata_ready_out(wdata_ready_out), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .rdata_valid_out(rdata_valid_out), .error_out(error_out), .busy_out(busy_out),
    .haddr_out(haddr_out), .htrans_out(htrans_out), .hburst_out(hburst_out),
    .hsize_out(hsize_out), .hwrite_out(hwrite_out), .hwdata_out(hwdata_out),
    .hready_in(hready_in), .hresp_in(hresp_in), .hrdata_in(hrdata_in));
  bas_slave u_slv (.clock_in(clock_in), .reset_n_in(reset_n_in), .htrans_in(htrans_out),
    .haddr_in(haddr_out), .slow_in(slow), .err_en_in(err_en), .err_addr_in(err_addr),
    .hready_out(hready_in), .hresp_out(hresp_in), .hrdata_out(hrdata_in));
  initial forever #50 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (hready_in && htrans_out[1]) begin
      if (nt == 0) begin
        fb = hburst_out;
        fz = hsize_out;
      end
      ta[nt] = haddr_out;
      nt++;
    end
    if (hready_in && wph) begin
      wd[nw] = hwdata_out;
      nw++;
    end
    if (hready_in) wph = htrans_out[1] && hwrite_out;
    if (rdata_valid_out) begin
      rd[nr] = rdata_out;
      nr++;
    end
    if (error_out) ne++;
  end
  task chk(input [31:0] g, input [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  function [31:0] ea(input [31:0] s, input [2:0] b, input [2:0] z, input int i);
    reg [31:0] sz, m, a;
    sz = 32'h1 << z;
    a = s & ~(sz - 32'h1);
    m = (32'h2 << b[2:1]) * sz - 32'h1;
    ea = (b[2:1] != 2'h0 && !b[0]) ? (a & ~m) | ((a + i * sz) & m) : a + i * sz;
  endfunction
  task burst(input [31:0] a, input [2:0] b, input [2:0] z, input w, input [7:0] l,
             input int gap, input int nb);
    int i, k;
    reg [2:0] zz;
    nt = 0; nr = 0; nw = 0; ne = 0;
    // Sizes above the 32-bit bus are expected to be issued as words
    zz = (z > 3'h2) ? 3'h2 : z;
    @(negedge clock_in);
    cmd_addr_in = a;
    cmd_burst_in = b;
    cmd_size_in = z;
    cmd_write_in = w;
    cmd_len_in = l;
    cmd_valid_in = 1'h1;
    for (k = 0; k < 50 && !cmd_ready_out; k++) @(negedge clock_in);
    @(negedge clock_in);
    cmd_valid_in = 1'h0;
    for (i = 0; w && i < nb; i++) begin
      wdata_in = 32'hC0DE0000 + i;
      wdata_valid_in = 1'h1;
      for (k = 0; k < 50 && !wdata_ready_out; k++) @(negedge clock_in);
      @(negedge clock_in);
      if (gap > 0) begin
        wdata_valid_in = 1'h0;
        repeat (gap) @(negedge clock_in);
      end
    end
    wdata_valid_in = 1'h0;
    for (k = 0; k < 400 && (k < 2 || busy_out); k++) @(negedge clock_in);
    repeat (3) @(negedge clock_in);
    chk(nt, nb);
    chk(w ? nw : nr, nb - ne);
    chk({29'h0, fz}, {29'h0, zz});
    for (i = 0; i < nt; i++) chk(ta[i], ea(a, b, zz, i));
    for (i = 0; i < nb - ne; i++)
      chk(w ? wd[i] : rd[i], w ? 32'hC0DE0000 + i : ea(a, b, zz, i) ^ 32'h5A5A0000);
  endtask
  task t_types;
    for (int b = 0; b < 8; b++)
      burst(32'h3C, b[2:0], 3'h2, 1'h0, 8'h3, 0, b < 2 ? b * 2 + 1 : 2 << b[2:1]);
    $display("types done");
  endtask
  task t_half;
    burst(32'h35, 3'h5, 3'h1, 1'h0, 8'h0, 0, 8);
    burst(32'h41, 3'h1, 3'h0, 1'h0, 8'h5, 0, 5);
    burst(32'h53, 3'h3, 3'h3, 1'h0, 8'h0, 0, 4);
    $display("halfword done");
  endtask
  task t_single;
    burst(32'h80, 3'h0, 3'h2, 1'h0, 8'h0, 0, 1);
    burst(32'h84, 3'h1, 3'h2, 1'h0, 8'h0, 0, 1);
    $display("single done");
  endtask
  task t_kb;
    burst(32'h3F8, 3'h3, 3'h2, 1'h0, 8'h0, 0, 4);
    chk({29'h0, fb}, 32'h1);
    $display("1KB done");
  endtask
  task t_slow;
    burst(32'h20, 3'h3, 3'h2, 1'h1, 8'h0, 3, 4);
    slow = 1'h1;
    burst(32'h34, 3'h2, 3'h2, 1'h0, 8'h0, 0, 4);
    burst(32'h100, 3'h7, 3'h2, 1'h1, 8'h0, 0, 16);
    slow = 1'h0;
    $display("slow done");
  endtask
  task t_err;
    err_en = 1'h1;
    err_addr = 32'h108;
    burst(32'h100, 3'h5, 3'h2, 1'h0, 8'h0, 0, 3);
    chk(ne, 1);
    err_en = 1'h0;
    burst(32'h100, 3'h5, 3'h2, 1'h0, 8'h0, 0, 8);
    $display("error done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (12) @(negedge clock_in);
    reset_n_in = 1'h1;
    t_types;
    t_half;
    t_single;
    t_kb;
    t_slow;
    t_err;
    complete_run;
  end
endmodule
